/* File: rtl/afcs_pkg.sv */
/*
 * Constants and layouts for the analog frequency command select block.
 * Assumes a 100 MHz clock_i and a single AHB-Lite master.
 */
package afcs_pkg;
  // register byte offsets and decode width
  localparam int ADDR_W = 8;
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  // configuration field positions
  localparam int CFG_PAIR_LSB = 0;
  localparam int CFG_TRIM_LSB = 2;
  localparam int CFG_FILT_LSB = 4;
  localparam int CFG_ASGN_BIT = 12;
  localparam int CFG_SRC_LSB = 16;
  // status field positions
  localparam int ST_FREQ_LSB = 0;
  localparam int ST_REV_BIT = 16;
  localparam int ST_ACT_BIT = 17;
  localparam int ST_BIPM_BIT = 18;
  localparam int ST_TRIM_BIT = 19;
  // setting encodings
  localparam logic [1:0] PAIR_VC = 2'h0;
  localparam logic [1:0] PAIR_VB = 2'h1;
  localparam logic [1:0] TRIM_BIP = 2'h0;
  localparam logic [1:0] TRIM_UNI = 2'h1;
  localparam logic [1:0] TRIM_BI = 2'h2;
  localparam logic [1:0] TRIM_OFF = 2'h3;
  localparam logic [7:0] SRC_ANALOG = 8'h01;
  // filter length limits and reset values
  localparam logic [4:0] FILT_MIN = 5'h01;
  localparam logic [4:0] FILT_MAX = 5'h1E;
  localparam int FILT_DEPTH = 30;
  localparam logic [4:0] FILT_RST = 5'h08;
  localparam logic [7:0] SRC_RST = 8'h01;
  localparam logic ASGN_RST = 1'b1;
  localparam logic [1:0] PAIR_RST = 2'h0;
  localparam logic [1:0] TRIM_RST = 2'h0;
  // sample and command widths, full-scale frequency code
  localparam int DW = 12;
  localparam int FW = 10;
  localparam logic [9:0] FREQ_MAX = 10'h3FF;
endpackage

/* File: rtl/afcs_reg_if.sv */
/*
 * Register access carrier between the bus slave and the block core.
 * Assumes one writer (the bus slave) and word-wide register access.
 */
`timescale 1ns/1ns
interface afcs_reg_if;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slv (output wr, output addr, output wdata, input rdata);
  modport core (input wr, input addr, input wdata, output rdata);
endinterface // afcs_reg_if

/* File: rtl/afcs_filter.sv */
/*
 * Moving-average filter for one signed analog channel.
 * Assumes n_i stays within 1..30; a change of n_i restarts the window.
 */
`timescale 1ns/1ns
module afcs_filter import afcs_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [4:0] n_i,
  input wire logic valid_i,
  input wire logic signed [11:0] x_i,
  output logic signed [11:0] y_o,
  output logic valid_o
);
  typedef struct packed {
    logic [FILT_DEPTH-1:0][DW-1:0] hist;
    logic signed [16:0] sum;
    logic [4:0] n_last;
    logic signed [DW-1:0] y;
    logic vld;
  } afcs_filt_t;
  afcs_filt_t s, n;

  // window update: add newest, drop the one leaving the window
  always_comb begin
    logic signed [16:0] old;
    old = '0;
    n = s;
    n.vld = 1'b0;
    if (valid_i) begin
      if (n_i != s.n_last) begin
        // restart keeps the sum consistent with the new window length
        n.hist = '0;
        n.sum = '0;
        n.n_last = n_i;
      end
      old = 17'(signed'(n.hist[5'(n_i - 5'h01)]));
      n.sum = 17'(n.sum + 17'(x_i) - old);
      n.hist = {n.hist[FILT_DEPTH-2:0], x_i};
      n.y = DW'(n.sum / signed'({12'h000, n_i}));
      n.vld = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign y_o = s.y;
  assign valid_o = s.vld;

  a_avg_single: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && n_i == 5'h01 |=> valid_o && y_o == $past(x_i))
    else $error("single-sample window does not pass the sample");
endmodule // afcs_filter

/* File: rtl/afcs_ahb.sv */
/*
 * AHB-Lite slave front end: one wait state per transfer, always OKAY.
 * Assumes single word transfers; the core answers reads combinationally.
 */
`timescale 1ns/1ns
module afcs_ahb import afcs_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  afcs_reg_if.slv rif
);
  typedef enum logic {AHB_IDLE = 1'b0, AHB_DATA = 1'b1} afcs_ahb_st_t;
  typedef struct packed {
    afcs_ahb_st_t st;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0] rdata;
    logic ready;
  } afcs_ahb_t;
  afcs_ahb_t s, n;

  // the wait state keeps a read right after a write from seeing stale data
  always_comb begin
    n = s;
    case (s.st)
      AHB_IDLE: begin
        if (hsel_i && htrans_i[1] && hready_i) begin
          n.st = AHB_DATA;
          n.wr = hwrite_i;
          n.addr = haddr_i[ADDR_W-1:0];
          n.ready = 1'b0;
        end
      end
      AHB_DATA: begin
        n.st = AHB_IDLE;
        n.ready = 1'b1;
        n.rdata = s.wr ? s.rdata : rif.rdata;
      end
      default: begin
        n.st = AHB_IDLE;
        n.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '{st: AHB_IDLE, wr: 1'b0, addr: 8'h00, rdata: 32'h0000_0000,
             ready: 1'b1};
    end else begin
      s <= n;
    end
  end

  // write strobe lands in the first data-phase cycle
  assign rif.wr = (s.st == AHB_DATA) && s.wr;
  assign rif.addr = s.addr;
  assign rif.wdata = hwdata_i;
  assign hrdata_o = s.rdata;
  assign hreadyout_o = s.ready;
endmodule // afcs_ahb

/* File: rtl/afcs_top.sv */
/*
 * Analog frequency command select: filters the voltage, current and
 * bipolar samples, routes them per the select terminal and settings,
 * and forms a saturated frequency command with a direction.
 * Assumes samples arrive with sample_valid_i, synchronous to clock_i,
 * and that software reaches the settings over AHB-Lite.
 */
`timescale 1ns/1ns
module afcs_top import afcs_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // digitised analog front end
  input wire logic sample_valid_i,
  input wire logic [9:0] voltage_input_i,
  input wire logic [9:0] current_input_i,
  input wire logic signed [10:0] bipolar_trim_input_i,
  input wire logic analog_type_select_i,
  // frequency command
  output logic [FW-1:0] freq_cmd_o,
  output logic reverse_o,
  output logic analog_active_o
);
  typedef struct packed {
    logic [1:0] input_pair_setting;
    logic [1:0] trim_mode_setting;
    logic [4:0] analog_filter_setting;
    logic select_assigned;
    logic [7:0] frequency_source_setting;
    logic [FW-1:0] freq;
    logic rev;
    logic active;
    logic bip_main;
    logic trim_on;
    logic [FW-1:0] bus_freq;
    logic bus_rev;
  } afcs_core_t;
  afcs_core_t s, n;

  afcs_reg_if rif ();

  logic signed [DW-1:0] filt_x [3];
  logic signed [DW-1:0] filt_y [3];
  logic [2:0] filt_v;
  logic upd;
  logic signed [13:0] v_s;
  logic signed [13:0] c_s;
  logic signed [13:0] b_s;
  logic [FW-1:0] vc_sat;
  logic [FW-1:0] b_abs;
  logic [2:0] size_unused;

  // clip to the command range: negative goes to zero, overflow to full scale
  function automatic logic [FW-1:0] sat_cmd(input logic signed [13:0] x);
    if (x < 14'sh0000) begin
      sat_cmd = 10'h000;
    end else if (x > 14'(FREQ_MAX)) begin
      sat_cmd = FREQ_MAX;
    end else begin
      sat_cmd = x[FW-1:0];
    end
  endfunction

  // filter length written outside 1..30 is pulled to the nearest limit
  function automatic logic [4:0] clamp_filt(input logic [4:0] f);
    if (f < FILT_MIN) begin
      clamp_filt = FILT_MIN;
    end else if (f > FILT_MAX) begin
      clamp_filt = FILT_MAX;
    end else begin
      clamp_filt = f;
    end
  endfunction

  // all three channels see the same filter length
  assign filt_x[0] = DW'($signed({2'h0, voltage_input_i}));
  assign filt_x[1] = DW'($signed({2'h0, current_input_i}));
  assign filt_x[2] = DW'(bipolar_trim_input_i);

  generate
    for (genvar g = 0; g < 3; g++) begin : g_filt
      afcs_filter u_filt (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .n_i(s.analog_filter_setting),
        .valid_i(sample_valid_i),
        .x_i(filt_x[g]),
        .y_o(filt_y[g]),
        .valid_o(filt_v[g])
      );
    end
  endgenerate

  // filtered channels widened so the sums cannot overflow
  assign upd = &filt_v;
  assign v_s = 14'(filt_y[0]);
  assign c_s = 14'(filt_y[1]);
  assign b_s = 14'(filt_y[2]);
  assign vc_sat = sat_cmd(14'(v_s + c_s));
  assign b_abs = sat_cmd((b_s < 14'sh0000) ? 14'(-b_s) : b_s);
  assign size_unused = hsize_i;

  afcs_ahb u_ahb (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hwdata_i(hwdata_i),
    .hready_i(hready_i),
    .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o),
    .rif(rif.slv)
  );

  // routing, trim and direction; settings writes share the same process
  always_comb begin
    logic signed [13:0] mainv;
    logic signed [13:0] trimv;
    logic signed [13:0] tot;
    logic signed [13:0] b_uni;
    logic bip_main;
    logic trim_on;
    logic rev_ok;
    bip_main = 1'b0;
    trim_on = 1'b0;
    rev_ok = 1'b0;
    tot = 14'sh0000;
    n = s;
    mainv = v_s;
    trimv = 14'sh0000;
    b_uni = (b_s < 14'sh0000) ? 14'sh0000 : b_s;
    if (s.select_assigned) begin
      bip_main = analog_type_select_i &&
                 (s.input_pair_setting == PAIR_VB);
      if (!analog_type_select_i) begin
        mainv = v_s;
      end else if (bip_main) begin
        mainv = b_s;
      end else begin
        mainv = c_s;
      end
      trim_on = ((s.trim_mode_setting == TRIM_UNI) ||
                 (s.trim_mode_setting == TRIM_BI)) && !bip_main;
      rev_ok = (s.trim_mode_setting == TRIM_BI) || bip_main;
    end else begin
      // pair setting deliberately not consulted here
      bip_main = (s.trim_mode_setting == TRIM_BIP);
      mainv = bip_main ? b_s : 14'(v_s + c_s);
      trim_on = (s.trim_mode_setting == TRIM_UNI) ||
                (s.trim_mode_setting == TRIM_BI);
      rev_ok = bip_main || (s.trim_mode_setting == TRIM_BI);
    end
    if (trim_on) begin
      trimv = (s.trim_mode_setting == TRIM_UNI) ? b_uni : b_s;
    end
    tot = 14'(mainv + trimv);
    if (upd) begin
      n.bip_main = bip_main;
      n.trim_on = trim_on;
      if (s.frequency_source_setting != SRC_ANALOG) begin
        n.freq = 10'h000;
        n.rev = 1'b0;
        n.active = 1'b0;
      end else if (rev_ok && (tot < 14'sh0000)) begin
        n.freq = sat_cmd(14'(-tot));
        n.rev = 1'b1;
        n.active = 1'b1;
      end else begin
        n.freq = sat_cmd(tot);
        n.rev = 1'b0;
        n.active = 1'b1;
      end
    end
    // status mirror for the bus, kept apart from the driven outputs
    n.bus_freq = n.freq;
    n.bus_rev = n.rev;
    if (rif.wr && (rif.addr == CFG_OFS)) begin
      n.input_pair_setting = rif.wdata[CFG_PAIR_LSB +: 2];
      n.trim_mode_setting = rif.wdata[CFG_TRIM_LSB +: 2];
      n.analog_filter_setting =
        clamp_filt(rif.wdata[CFG_FILT_LSB +: 5]);
      n.select_assigned = rif.wdata[CFG_ASGN_BIT];
      n.frequency_source_setting = rif.wdata[CFG_SRC_LSB +: 8];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '{input_pair_setting: PAIR_RST, trim_mode_setting: TRIM_RST,
             analog_filter_setting: FILT_RST, select_assigned: ASGN_RST,
             frequency_source_setting: SRC_RST, freq: 10'h000,
             rev: 1'b0, active: 1'b0, bip_main: 1'b0, trim_on: 1'b0,
             bus_freq: 10'h000, bus_rev: 1'b0};
    end else begin
      s <= n;
    end
  end

  // read decode; unmapped offsets read zero
  always_comb begin
    rif.rdata = 32'h0000_0000;
    case (rif.addr)
      CFG_OFS: begin
        rif.rdata[CFG_PAIR_LSB +: 2] = s.input_pair_setting;
        rif.rdata[CFG_TRIM_LSB +: 2] = s.trim_mode_setting;
        rif.rdata[CFG_FILT_LSB +: 5] = s.analog_filter_setting;
        rif.rdata[CFG_ASGN_BIT] = s.select_assigned;
        rif.rdata[CFG_SRC_LSB +: 8] = s.frequency_source_setting;
      end
      STAT_OFS: begin
        rif.rdata[ST_FREQ_LSB +: FW] = s.bus_freq;
        rif.rdata[ST_REV_BIT] = s.bus_rev;
        rif.rdata[ST_ACT_BIT] = s.active;
        rif.rdata[ST_BIPM_BIT] = s.bip_main;
        rif.rdata[ST_TRIM_BIT] = s.trim_on;
      end
      default: begin
        rif.rdata = 32'h0000_0000;
      end
    endcase
  end

  assign freq_cmd_o = s.freq;
  assign reverse_o = s.rev;
  assign analog_active_o = s.active;
  assign hresp_o = 1'b0; // every transfer answers OKAY

  // checks: outputs follow one cycle after a filtered sample set
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_src_gate: assert property (
    upd && s.frequency_source_setting != SRC_ANALOG
    |=> freq_cmd_o == 10'h000 && !analog_active_o && !reverse_o)
    else $error("command not gated by frequency source");

  a_volt_off: assert property (
    upd && s.frequency_source_setting == SRC_ANALOG && s.select_assigned &&
    !analog_type_select_i && s.trim_mode_setting == TRIM_OFF
    |=> freq_cmd_o == $past(v_s[FW-1:0]) && !reverse_o)
    else $error("terminal off does not select voltage input");

  a_cur_on: assert property (
    upd && s.frequency_source_setting == SRC_ANALOG && s.select_assigned &&
    analog_type_select_i && s.input_pair_setting == PAIR_VC &&
    s.trim_mode_setting == TRIM_OFF
    |=> freq_cmd_o == $past(c_s[FW-1:0]) && !reverse_o)
    else $error("terminal on with pair 00 does not select current input");

  a_bip_dir: assert property (
    upd && s.frequency_source_setting == SRC_ANALOG && s.select_assigned &&
    analog_type_select_i && s.input_pair_setting == PAIR_VB
    |=> reverse_o == $past(b_s < 14'sh0000) && freq_cmd_o == $past(b_abs))
    else $error("bipolar main command direction or size wrong");

  a_no_trim_main: assert property (
    upd && s.frequency_source_setting == SRC_ANALOG && s.select_assigned &&
    analog_type_select_i && s.input_pair_setting == PAIR_VB
    |=> !s.trim_on && s.bip_main)
    else $error("trim offered while bipolar input is main");

  a_rev_mode2: assert property (
    upd && s.frequency_source_setting == SRC_ANALOG && s.select_assigned &&
    !analog_type_select_i && s.trim_mode_setting == TRIM_BI &&
    v_s == 14'sh0000 && b_s < 14'sh0000
    |=> reverse_o && freq_cmd_o == $past(b_abs))
    else $error("mode 02 does not permit reverse");

  a_sum_vc: assert property (
    upd && s.frequency_source_setting == SRC_ANALOG && !s.select_assigned &&
    s.trim_mode_setting == TRIM_OFF
    |=> freq_cmd_o == $past(vc_sat) && !reverse_o)
    else $error("unassigned mode 03 does not sum voltage and current");

  a_pair_ignored: assert property (
    upd && !s.select_assigned && s.trim_mode_setting == TRIM_BIP &&
    s.frequency_source_setting == SRC_ANALOG
    |=> freq_cmd_o == $past(b_abs) && s.bip_main)
    else $error("unassigned mode 00 not driven by bipolar input alone");

  a_unipolar_m1: assert property (
    upd && s.frequency_source_setting == SRC_ANALOG &&
    s.trim_mode_setting == TRIM_UNI && !s.bip_main && !n.bip_main
    |=> !reverse_o)
    else $error("mode 01 produced reverse from the trim input");

  a_sat_top: assert property (
    upd && s.frequency_source_setting == SRC_ANALOG && !s.select_assigned &&
    s.trim_mode_setting == TRIM_UNI && 14'(v_s + c_s) >= 14'(FREQ_MAX)
    |=> freq_cmd_o == FREQ_MAX)
    else $error("summed command not saturated at full scale");

  a_filt_range: assert property (
    s.analog_filter_setting >= FILT_MIN &&
    s.analog_filter_setting <= FILT_MAX)
    else $error("filter length outside 1..30");

  a_trim_add: assert property (
    upd && s.frequency_source_setting == SRC_ANALOG && s.select_assigned &&
    !analog_type_select_i && s.trim_mode_setting == TRIM_BI &&
    b_s >= 14'sh0000
    |=> freq_cmd_o == $past(sat_cmd(14'(v_s + b_s))))
    else $error("trim offset not added to main command");
endmodule // afcs_top

/* File: tb/afcs_front_model.sv */
/*
 * Model of the digitised analog front end: voltage, current and bipolar
 * channels, one sample set per request.
 * Assumes send is called just after a rising edge of clock_i.
 */
`timescale 1ns/1ns
module afcs_front_model (
  input wire logic clock_i,
  output logic sample_valid_o,
  output logic [9:0] voltage_o,
  output logic [9:0] current_o,
  output logic signed [10:0] bipolar_o
);
  // idle front end at time zero
  initial begin
    sample_valid_o = 1'b0;
    voltage_o = 10'h000;
    current_o = 10'h000;
    bipolar_o = 11'h000;
  end

  // one set for one cycle; afterwards the lines carry the inverse, so a
  // core that samples late or twice sees garbage instead of a lucky match
  task automatic send(input logic [9:0] v, input logic [9:0] c,
                      input logic signed [10:0] b);
    sample_valid_o <= 1'b1;
    voltage_o <= v;
    current_o <= c;
    bipolar_o <= b;
    @(posedge clock_i);
    sample_valid_o <= 1'b0;
    voltage_o <= ~v;
    current_o <= ~c;
    bipolar_o <= ~b;
  endtask
endmodule // afcs_front_model

/* File: tb/analog_freq_command_select_bench.sv */
/*
 * Self-checking bench for afcs_top: settings over AHB-Lite, samples from
 * the front-end model, command outputs and status compared to a model.
 * Assumes a single bus master with hready looped back from hreadyout.
 */
`timescale 1ns/1ns
module analog_freq_command_select_bench import afcs_pkg::*;;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic at_sel = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, valid, rev, act;
  logic [9:0] volt, cur;
  logic signed [10:0] bip;
  logic [FW-1:0] freq;
  logic [31:0] rd;
  int n_fail = 0;
  int n_checks = 0;

  // 100 MHz clock
  always #5 clock_i = ~clock_i;

  afcs_front_model front (.clock_i(clock_i), .sample_valid_o(valid),
    .voltage_o(volt), .current_o(cur), .bipolar_o(bip));

  afcs_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .sample_valid_i(valid), .voltage_input_i(volt),
    .current_input_i(cur), .bipolar_trim_input_i(bip),
    .analog_type_select_i(at_sel), .freq_cmd_o(freq), .reverse_o(rev),
    .analog_active_o(act));

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg,
               got, exp);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // single AHB-Lite transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clock_i);
    while (hreadyout !== 1'b1) @(posedge clock_i);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock_i);
    while (hreadyout !== 1'b1) @(posedge clock_i);
    rdv = hrdata;
  endtask

  function automatic logic [31:0] cfg_word(input logic [7:0] src,
      input logic asg, input logic [4:0] filt, input logic [1:0] tm,
      input logic [1:0] pr);
    return (32'(src) << CFG_SRC_LSB) | (32'(asg) << CFG_ASGN_BIT) |
           (32'(filt) << CFG_FILT_LSB) | (32'(tm) << CFG_TRIM_LSB) |
           32'(pr);
  endfunction

  // expected {trim on, bipolar main, reverse, freq} from the routing tables
  function automatic logic [12:0] expect_cmd(input int asg, input int pr,
      input int tm, input int at, input int v, input int c, input int b);
    int main, tot;
    bit bipm, ton, rok, rv;
    if (asg != 0) begin
      bipm = (pr == 1) && (at != 0);
      main = bipm ? b : ((at != 0) ? c : v);
      ton = (tm == 1 || tm == 2) && !bipm;
      rok = (tm == 2) || bipm;
    end else begin
      bipm = (tm == 0);
      main = bipm ? b : v + c;
      ton = (tm == 1 || tm == 2);
      rok = (tm == 0 || tm == 2);
    end
    tot = main + (ton ? ((tm == 1 && b < 0) ? 0 : b) : 0);
    if (!rok && tot < 0) tot = 0;
    rv = tot < 0;
    if (rv) tot = -tot;
    if (tot > 1023) tot = 1023;
    return {ton, bipm, rv, tot[9:0]};
  endfunction

  // one sample set, then wait three more edges so outputs have landed
  task automatic sample(input int v, input int c, input int b);
    front.send(10'(v), 10'(c), 11'(b));
    repeat (3) @(posedge clock_i);
  endtask

  task automatic t_reset();
    check(32'({freq, rev, act, hresp, hreadyout}), 32'h0000_0001,
          "reset out");
    bus(1'b0, 32'(CFG_OFS), 32'h0000_0000, rd);
    check(rd, cfg_word(SRC_RST, ASGN_RST, FILT_RST, TRIM_RST, PAIR_RST),
          "cfg reset");
    bus(1'b0, 32'(STAT_OFS), 32'h0000_0000, rd);
    check(rd, 32'h0000_0000, "status reset");
    // unmapped word: write dropped, read gives zero
    bus(1'b1, 32'h0000_0008, 32'hFFFF_FFFF, rd);
    bus(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
    check(rd | 32'(hresp), 32'h0000_0000, "unmapped");
  endtask

  // filter setting clamps to its documented range
  task automatic t_clamp();
    bus(1'b1, 32'(CFG_OFS), cfg_word(SRC_ANALOG, 1'b1, 5'h00, 2'h3, 2'h0),
        rd);
    bus(1'b0, 32'(CFG_OFS), 32'h0000_0000, rd);
    check(32'(rd[8:4]), 32'(FILT_MIN), "filter low");
    bus(1'b1, 32'(CFG_OFS), cfg_word(SRC_ANALOG, 1'b1, 5'h1F, 2'h3, 2'h0),
        rd);
    bus(1'b0, 32'(CFG_OFS), 32'h0000_0000, rd);
    check(32'(rd[8:4]), 32'(FILT_MAX), "filter high");
  endtask

  // every assignment, pair, trim mode and terminal level, filter of one
  task automatic t_table();
    int vv[3] = '{300, 900, 1023};
    int cc[3] = '{500, 400, 1023};
    int bb[3] = '{-200, 600, -1023};
    logic [12:0] e;
    for (int a = 0; a < 2; a++) begin
      for (int p = 0; p < 2; p++) begin
        for (int t = 0; t < 4; t++) begin
          bus(1'b1, 32'(CFG_OFS),
              cfg_word(SRC_ANALOG, 1'(a), 5'h01, 2'(t), 2'(p)), rd);
          for (int s = 0; s < 2; s++) begin
            at_sel <= 1'(s);
            for (int k = 0; k < 3; k++) begin
              e = expect_cmd(a, p, t, s, vv[k], cc[k], bb[k]);
              sample(vv[k], cc[k], bb[k]);
              check(32'({act, rev, freq}),
                    32'({1'b1, e[10:0]}), "command");
              bus(1'b0, 32'(STAT_OFS), 32'h0000_0000, rd);
              check(32'({rd[19:16], rd[9:0]}),
                    32'({e[12:11], 1'b1, e[10:0]}), "status");
            end
          end
        end
      end
    end
  endtask

  // analog command in use only with the analog source selected
  task automatic t_source();
    logic [7:0] srcs[3] = '{8'h00, 8'h02, SRC_ANALOG};
    // terminal off so the voltage sample is what a live command shows
    at_sel <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 32'(CFG_OFS), cfg_word(srcs[i], 1'b1, 5'h01, 2'h3, 2'h0),
          rd);
      sample(100, 0, 0);
      check(32'(act), 32'(i == 2), "active");
      check(32'(freq),
            (i == 2) ? 32'h0000_0064 : 32'h0000_0000, "gated");
      bus(1'b0, 32'(STAT_OFS), 32'h0000_0000, rd);
      check(32'(rd[17]), 32'(i == 2), "status active");
    end
  endtask

  // mode 02: a negative trim on a zero main command runs in reverse
  task automatic t_trim_rev();
    at_sel <= 1'b0;
    bus(1'b1, 32'(CFG_OFS), cfg_word(SRC_ANALOG, 1'b1, 5'h01, 2'h2, 2'h0),
        rd);
    sample(0, 0, -300);
    check(32'({rev, freq}), 32'h0000_052C, "trim reverse");
  endtask

  // window of three after a length change ramps from zero
  task automatic t_avg();
    int exp3[3] = '{2, 4, 7};
    at_sel <= 1'b0;
    bus(1'b1, 32'(CFG_OFS), cfg_word(SRC_ANALOG, 1'b1, 5'h03, 2'h3, 2'h0),
        rd);
    for (int i = 0; i < 3; i++) begin
      sample(7, 5, 3);
      check(32'(freq), 32'(exp3[i]), "average");
    end
  endtask

  // ends a hung run well past the expected run of under a thousand cycles
  initial begin
    #500_000;
    n_fail++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    t_reset();
    t_clamp();
    t_table();
    t_source();
    t_trim_rev();
    t_avg();
    final_report();
  end
endmodule // analog_freq_command_select_bench
